// file: hdl/pieb_top.sv
`timescale 1ns/1ns
`include "pieb_defs.svh"
// Operation
// - no peripheral request reaches the core on periph_irq later than one cycle after the global enable is cleared; irq is not gated by it
// - capture bank: unit5 bit 6, unit4 bit 5, unit3 bit 4, writable, reset 0
// - enable 1 lets its source through, 0 blocks it
// - capture bank: timer six match bit 3, timer four match bit 1
// - unimplemented bits read as zero in both banks
module pieb_top
  import pieb_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [`PIEB_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire pieb_src_t src_flags,
  output logic periph_irq,
  output logic irq
);
  logic [7:0] irq_enable_capture_timer;
  logic [7:0] irq_enable_serial_second;
  logic [7:0] core_irq_control_register;
  logic [`PIEB_EV_W-1:0] ev_status;
  logic [`PIEB_EV_W-1:0] ev_mask;
  logic global_peripheral_irq_enable;
  pieb_state_t state;
  pieb_src_t enables;
  pieb_src_t pending;
  logic periph_irq_q;
  logic wr_go;
  logic rd_go;
  logic [`PIEB_EV_W-1:0] ev_set;
  logic [7:0] next_ev_mask;

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  // one wait state per access keeps read data registered
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      state <= PIEB_IDLE;
    else
    begin
      case (state)
        PIEB_IDLE: if (avs_read || avs_write) state <= PIEB_ACK;
        PIEB_ACK: state <= PIEB_IDLE;
        default: state <= PIEB_IDLE;
      endcase
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && (state != PIEB_ACK);
  assign wr_go = avs_write && (state == PIEB_ACK);
  assign rd_go = avs_read && (state == PIEB_IDLE);

  function automatic logic [7:0] pieb_wr8(input logic [7:0] old, input logic [7:0] impl);
    pieb_wr8 = avs_byteenable[0] ? (avs_writedata[7:0] & impl) : old;
  endfunction

  assign next_ev_mask = pieb_wr8({6'h00, ev_mask}, 8'h03);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_enable_capture_timer <= `PIEB_RST_EN;
      irq_enable_serial_second <= `PIEB_RST_EN;
      core_irq_control_register <= 8'h00;
      ev_mask <= '0;
    end
    else if (wr_go)
    begin
      case (avs_address)
        `PIEB_OFS_EN_CT: irq_enable_capture_timer <=
          pieb_wr8(irq_enable_capture_timer, `PIEB_MASK_CT);
        `PIEB_OFS_EN_SS: irq_enable_serial_second <=
          pieb_wr8(irq_enable_serial_second, `PIEB_MASK_SS);
        `PIEB_OFS_CTRL: core_irq_control_register <= pieb_wr8(core_irq_control_register, 8'h01);
        `PIEB_OFS_MASK: ev_mask <= next_ev_mask[`PIEB_EV_W-1:0];
        default: ;
      endcase
    end
  end

  assign global_peripheral_irq_enable = core_irq_control_register[`PIEB_BIT_GPE];
  assign enables.ct = irq_enable_capture_timer;
  assign enables.ss = irq_enable_serial_second;

  // ------------------------------------------------------------
  // gating
  // ------------------------------------------------------------
  pieb_gate u_gate (
    .mclk(mclk),
    .resetn(resetn),
    .flags(src_flags),
    .enables(enables),
    .global_peripheral_irq_enable(global_peripheral_irq_enable),
    .periph_irq(periph_irq),
    .pending(pending)
  );

  // ------------------------------------------------------------
  // events: request raised and dropped
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      periph_irq_q <= 1'b0;
    else
      periph_irq_q <= periph_irq;
  end

  assign ev_set = {periph_irq_q & ~periph_irq, periph_irq & ~periph_irq_q};

  // set beats a write-one clear in the same cycle
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      ev_status <= '0;
    else if (wr_go && avs_address == `PIEB_OFS_STAT && avs_byteenable[0])
      ev_status <= (ev_status & ~avs_writedata[`PIEB_EV_W-1:0]) | ev_set;
    else
      ev_status <= ev_status | ev_set;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(ev_status & ev_mask);
  end

  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
      avs_readdata <= 32'h0000_0000;
    else if (rd_go)
    begin
      case (avs_address)
        `PIEB_OFS_EN_CT: avs_readdata <= {24'h0, irq_enable_capture_timer & `PIEB_MASK_CT};
        `PIEB_OFS_EN_SS: avs_readdata <= {24'h0, irq_enable_serial_second & `PIEB_MASK_SS};
        `PIEB_OFS_CTRL: avs_readdata <= {24'h0, core_irq_control_register};
        `PIEB_OFS_STAT: avs_readdata <= {30'h0, ev_status};
        `PIEB_OFS_MASK: avs_readdata <= {30'h0, ev_mask};
        `PIEB_OFS_PEND: avs_readdata <= {16'h0, pending.ct, pending.ss};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_reserved_ct_zero: assert property (@(posedge mclk) disable iff (!resetn)
    (irq_enable_capture_timer & ~`PIEB_MASK_CT) == 8'h00)
    else $error("capture bank reserved bit set");
  a_reserved_ss_zero: assert property (@(posedge mclk) disable iff (!resetn)
    (irq_enable_serial_second & ~`PIEB_MASK_SS) == 8'h00)
    else $error("serial bank reserved bit set");
  a_cc5_write_lands: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_go && avs_address == `PIEB_OFS_EN_CT && avs_byteenable[0]) |=>
    irq_enable_capture_timer[`PIEB_BIT_CC5] == $past(avs_writedata[`PIEB_BIT_CC5]))
    else $error("unit5 enable not written");
  a_t6_write_lands: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_go && avs_address == `PIEB_OFS_EN_CT && avs_byteenable[0]) |=>
    irq_enable_capture_timer[`PIEB_BIT_T6] == $past(avs_writedata[`PIEB_BIT_T6]))
    else $error("timer six enable not written");
  a_rx2_write_lands: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_go && avs_address == `PIEB_OFS_EN_SS && avs_byteenable[0]) |=>
    irq_enable_serial_second[`PIEB_BIT_RX2] == $past(avs_writedata[`PIEB_BIT_RX2]))
    else $error("rx enable not written");
  a_tx2_write_lands: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_go && avs_address == `PIEB_OFS_EN_SS && avs_byteenable[0]) |=>
    irq_enable_serial_second[`PIEB_BIT_TX2] == $past(avs_writedata[`PIEB_BIT_TX2]))
    else $error("tx enable not written");
  a_bc2_write_lands: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_go && avs_address == `PIEB_OFS_EN_SS && avs_byteenable[0]) |=>
    irq_enable_serial_second[`PIEB_BIT_BC2] == $past(avs_writedata[`PIEB_BIT_BC2]))
    else $error("collision enable not written");
  a_sp2_write_lands: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_go && avs_address == `PIEB_OFS_EN_SS && avs_byteenable[0]) |=>
    irq_enable_serial_second[`PIEB_BIT_SP2] == $past(avs_writedata[`PIEB_BIT_SP2]))
    else $error("transfer enable not written");
  a_cc4_write_lands: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_go && avs_address == `PIEB_OFS_EN_CT && avs_byteenable[0]) |=>
    irq_enable_capture_timer[`PIEB_BIT_CC4] == $past(avs_writedata[`PIEB_BIT_CC4]))
    else $error("unit4 enable not written");
  a_cc3_write_lands: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_go && avs_address == `PIEB_OFS_EN_CT && avs_byteenable[0]) |=>
    irq_enable_capture_timer[`PIEB_BIT_CC3] == $past(avs_writedata[`PIEB_BIT_CC3]))
    else $error("unit3 enable not written");
  a_t4_write_lands: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_go && avs_address == `PIEB_OFS_EN_CT && avs_byteenable[0]) |=>
    irq_enable_capture_timer[`PIEB_BIT_T4] == $past(avs_writedata[`PIEB_BIT_T4]))
    else $error("timer four enable not written");
  a_gpe_write_lands: assert property (@(posedge mclk) disable iff (!resetn)
    (wr_go && avs_address == `PIEB_OFS_CTRL && avs_byteenable[0]) |=>
    global_peripheral_irq_enable == $past(avs_writedata[`PIEB_BIT_GPE]))
    else $error("global enable not written");
  a_enable_passes: assert property (@(posedge mclk) disable iff (!resetn)
    (src_flags.ct[`PIEB_BIT_CC3] && enables.ct[`PIEB_BIT_CC3] && global_peripheral_irq_enable)
    |=> periph_irq)
    else $error("enabled source blocked");
  a_disable_blocks: assert property (@(posedge mclk) disable iff (!resetn)
    (enables == '0) |=> !periph_irq)
    else $error("disabled source passed");
  a_global_off: assert property (@(posedge mclk) disable iff (!resetn)
    !global_peripheral_irq_enable ##1 !global_peripheral_irq_enable |-> !periph_irq)
    else $error("request with global enable clear");
endmodule

// file: hdl/pieb_defs.svh
`ifndef PIEB_DEFS_SVH
`define PIEB_DEFS_SVH

// byte addresses of the register words
`define PIEB_OFS_EN_CT 5'h00
`define PIEB_OFS_EN_SS 5'h04
`define PIEB_OFS_CTRL 5'h08
`define PIEB_OFS_STAT 5'h0c
`define PIEB_OFS_MASK 5'h10
`define PIEB_OFS_PEND 5'h14
`define PIEB_ADDR_W 5

// capture/timer bank fields
`define PIEB_BIT_CC5 6
`define PIEB_BIT_CC4 5
`define PIEB_BIT_CC3 4
`define PIEB_BIT_T6 3
`define PIEB_BIT_T4 1
`define PIEB_MASK_CT 8'h7a

// second serial bank fields
`define PIEB_BIT_RX2 5
`define PIEB_BIT_TX2 4
`define PIEB_BIT_BC2 1
`define PIEB_BIT_SP2 0
`define PIEB_MASK_SS 8'h33

// control bit 0: global peripheral enable
`define PIEB_BIT_GPE 0

// event status bits
`define PIEB_EV_RISE 0
`define PIEB_EV_FALL 1
`define PIEB_EV_W 2

`define PIEB_RST_EN 8'h00

`endif

// file: hdl/pieb_pkg.sv
package pieb_pkg;
  typedef struct packed {
    logic [7:0] ct;
    logic [7:0] ss;
  } pieb_src_t;

  typedef enum logic [1:0] {
    PIEB_IDLE = 2'b00,
    PIEB_ACK = 2'b01
  } pieb_state_t;
endpackage

// file: hdl/pieb_gate.sv
`timescale 1ns/1ns
`include "pieb_defs.svh"
module pieb_gate
  import pieb_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire pieb_src_t flags,
  input wire pieb_src_t enables,
  input wire logic global_peripheral_irq_enable,
  output logic periph_irq,
  output pieb_src_t pending
);
  pieb_src_t next_pending;

  always_comb
  begin
    next_pending.ct = flags.ct & enables.ct & `PIEB_MASK_CT;
    next_pending.ss = flags.ss & enables.ss & `PIEB_MASK_SS;
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pending <= '0;
      periph_irq <= 1'b0;
    end
    else
    begin
      pending <= next_pending;
      // global gate sits last so no single enable can bypass it
      periph_irq <= global_peripheral_irq_enable & (|next_pending);
    end
  end

  a_global_gate_block: assert property (@(posedge mclk) disable iff (!resetn)
    !$past(global_peripheral_irq_enable) |-> !periph_irq)
    else $error("request passed with global enable clear");
endmodule

// file: tb/pieb_test.sv
`timescale 1ns/1ns
`include "pieb_defs.svh"
module pieb_test
  import pieb_pkg::*;
;
  logic mclk;
  logic resetn;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  pieb_src_t src_flags;
  logic periph_irq;
  logic irq;
  logic [31:0] rd;
  logic [15:0] m;
  logic [3:0] be;
  int mismatches;
  int n_checks;

  pieb_top pieb_top_inst (
    .mclk(mclk),
    .resetn(resetn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .src_flags(src_flags),
    .periph_irq(periph_irq),
    .irq(irq)
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------
  // bus access and comparison
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // holds the request until waitrequest is seen low at a rising edge
  task automatic bus_xfer(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50)
      chk(32'h0000dead, 32'h00000000);
    @(posedge mclk);
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    bus_xfer(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask

  // status to irq takes two registered stages after periph_irq
  task automatic settle();
    repeat (4) @(posedge mclk);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    resetn = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'h0;
    be = 4'hf;
    src_flags = 16'h0000;
    mismatches = 0;
    n_checks = 0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd_chk(5'h00, 32'h0);
    rd_chk(5'h04, 32'h0);
    rd_chk(5'h08, 32'h0);
    bus_xfer(1'b1, 5'h00, 8'hff);
    rd_chk(5'h00, 32'h7a);
    bus_xfer(1'b1, 5'h04, 8'hff);
    rd_chk(5'h04, 32'h33);
    // global enable off: nothing passes even with everything enabled
    src_flags <= 16'hffff;
    settle();
    chk(periph_irq, 1'b0);
    rd_chk(5'h14, 32'h7a33);
    bus_xfer(1'b1, 5'h08, 8'h01);
    // walk every bit, implemented or not, with only it enabled
    for (int i = 0; i < 16; i++)
    begin
      m = 16'h0001 << i;
      bus_xfer(1'b1, 5'h00, m[15:8]);
      bus_xfer(1'b1, 5'h04, m[7:0]);
      src_flags <= m;
      settle();
      chk(periph_irq, (m & 16'h7a33) != 16'h0000);
      rd_chk(5'h14, m & 16'h7a33);
      src_flags <= ~m;
      settle();
      chk(periph_irq, 1'b0);
    end
    // event status, mask and level interrupt
    src_flags <= 16'h0000;
    bus_xfer(1'b1, 5'h04, 8'h01);
    bus_xfer(1'b1, 5'h0c, 8'h03);
    rd_chk(5'h0c, 32'h0);
    bus_xfer(1'b1, 5'h10, 8'h01);
    src_flags <= 16'h0001;
    settle();
    chk(irq, 1'b1);
    src_flags <= 16'h0000;
    settle();
    rd_chk(5'h0c, 32'h3);
    bus_xfer(1'b1, 5'h0c, 8'h01);
    settle();
    chk(irq, 1'b0);
    bus_xfer(1'b1, 5'h10, 8'h02);
    settle();
    chk(irq, 1'b1);
    bus_xfer(1'b1, 5'h0c, 8'h02);
    settle();
    chk(irq, 1'b0);
    // clearing the global enable blocks a live request
    src_flags <= 16'h0001;
    settle();
    chk(periph_irq, 1'b1);
    bus_xfer(1'b1, 5'h08, 8'h00);
    settle();
    chk(periph_irq, 1'b0);
    bus_xfer(1'b1, 5'h1c, 8'hff);
    rd_chk(5'h18, 32'h0);
    // lane 0 disabled: the write must leave the bank alone
    be = 4'he;
    bus_xfer(1'b1, 5'h00, 8'hff);
    be = 4'hf;
    rd_chk(5'h00, 32'h0);
    conclude();
  end

  // whole run is a few hundred cycles; this is a generous margin
  initial
  begin
    #200000;
    mismatches++;
    conclude();
  end
endmodule
